// ---- verilog/fpst_map.svh ----
// Offsets, field positions, reset values and encodings of the fp status block
`ifndef FPST_MAP_SVH
`define FPST_MAP_SVH

`define FPST_ADDR_TRAPS 12'h000
`define FPST_ADDR_SF_BASE 12'h004
`define FPST_ADDR_SF_LAST 12'h010

`define FPST_SF_FTZ 0
`define FPST_SF_WRE 1
`define FPST_SF_PC_LO 2
`define FPST_SF_RC_LO 4
`define FPST_SF_TD 6
`define FPST_SF_FLAG_LO 7

`define FPST_EX_V 0
`define FPST_EX_D 1
`define FPST_EX_Z 2
`define FPST_EX_O 3
`define FPST_EX_U 4
`define FPST_EX_I 5

`define FPST_TRAPS_RST 6'h3f
`define FPST_SF_RST 13'h000c

`define FPST_PC_SINGLE 2'h0
`define FPST_PC_DOUBLE 2'h2

`define FPST_EXP_MAX 17'h1ffff
`define FPST_EXP_INT 17'h1003e
`define FPST_SIG_EXPMOVE 64'h8000000000000000
`define FPST_SGL_ADJ 17'h0ff80
`define FPST_SGL_DEN 17'h0ff81
`define FPST_DBL_ADJ 17'h0fc00
`define FPST_DBL_DEN 17'h0fc01
`define FPST_EXT_ADJ 17'h0c000
`define FPST_DEFERRED_EXCEPTION_VALUE {1'b0, 17'h1fffe, 64'h0000000000000000}

`define FPST_BYTES_SGL 5'h04
`define FPST_BYTES_DBL 5'h08
`define FPST_BYTES_EXT 5'h0a
`define FPST_BYTES_SPILL 5'h10

`endif

// ---- verilog/fpst_pkg.sv ----
// Types and shared helpers of the fp status and transfer block
`default_nettype none
package fpst_pkg;
  `include "fpst_map.svh"

  typedef enum logic [2:0] {
    OP_LOAD = 3'h0,
    OP_LOAD_PAIR = 3'h1,
    OP_STORE = 3'h2,
    OP_SETF = 3'h3,
    OP_GETF = 3'h4
  } fpst_op_type;

  typedef enum logic [2:0] {
    FMT_SINGLE = 3'h0,
    FMT_DOUBLE = 3'h1,
    FMT_EXT = 3'h2,
    FMT_INT = 3'h3,
    FMT_SPILL = 3'h4,
    FMT_SIG = 3'h5,
    FMT_EXP = 3'h6
  } fpst_fmt_type;

  typedef enum logic [1:0] {
    PC_NONE = 2'h0,
    PC_SINGLE = 2'h1,
    PC_DOUBLE = 2'h2
  } fpst_pc_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_MEM = 3'h1,
    ST_WR1 = 3'h2,
    ST_WR2 = 3'h3,
    ST_RDREG = 3'h4,
    ST_SRC = 3'h5,
    ST_FINISH = 3'h6
  } fpst_state_type;

  typedef logic [81:0] fpst_freg_type;

  function automatic logic [4:0] fpst_bytes(input fpst_fmt_type f);
    case (f)
      FMT_SINGLE: return `FPST_BYTES_SGL;
      FMT_EXT: return `FPST_BYTES_EXT;
      FMT_SPILL: return `FPST_BYTES_SPILL;
      default: return `FPST_BYTES_DBL;
    endcase
  endfunction

  // Reverses the low n bytes; bytes above n pass unchanged
  function automatic logic [127:0] fpst_bswap(input logic [127:0] d,
                                              input logic [4:0] n);
    logic [127:0] r;
    r = d;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(n)) begin
        r[8*i +: 8] = d[8*(int'(n) - 1 - i) +: 8];
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ---- verilog/fpst_regfile.sv ----
// Small fp register file with a registered read port
`default_nettype none
module fpst_regfile (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire fpst_pkg::fpst_freg_type wdata,
  input wire logic [2:0] raddr,
  output fpst_pkg::fpst_freg_type rdata
);
  import fpst_pkg::*;

  fpst_freg_type mem [0:7];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ---- verilog/fpst_conv.sv ----
// Memory and general register format translation to and from fp registers
`default_nettype none
module fpst_conv (
  input wire fpst_pkg::fpst_fmt_type fmt,
  input wire logic big_endian,
  input wire logic [127:0] mem_in,
  input wire fpst_pkg::fpst_freg_type reg_in,
  output fpst_pkg::fpst_freg_type reg_out,
  output logic [127:0] mem_out
);
  import fpst_pkg::*;

  wire [4:0] nbytes = fpst_bytes(fmt);
  // Single and double swap like 32 and 64 bit integers
  wire [127:0] m = big_endian ? fpst_bswap(mem_in, nbytes) : mem_in;
  wire rs = reg_in[81];
  wire [16:0] re = reg_in[80:64];
  wire [63:0] rg = reg_in[63:0];
  wire [16:0] sgl_e = re - `FPST_SGL_ADJ;
  wire [16:0] dbl_e = re - `FPST_DBL_ADJ;
  wire [16:0] ext_e = re - `FPST_EXT_ADJ;
  logic [127:0] raw;

  assign mem_out = big_endian ? fpst_bswap(raw, nbytes) : raw;

  always_comb begin
    reg_out = {m[81:64], m[63:0]};
    case (fmt)
      FMT_SINGLE: begin
        if (m[30:23] == 8'hff) begin
          reg_out = {m[31], `FPST_EXP_MAX, 1'b1, m[22:0], 40'h0};
        end else if (m[30:23] == 8'h00) begin
          reg_out = (m[22:0] == 23'h0) ? {m[31], 81'h0} :
                    {m[31], `FPST_SGL_DEN, 1'b0, m[22:0], 40'h0};
        end else begin
          reg_out = {m[31], {9'h0, m[30:23]} + `FPST_SGL_ADJ, 1'b1,
                     m[22:0], 40'h0};
        end
      end
      FMT_DOUBLE: begin
        if (m[62:52] == 11'h7ff) begin
          reg_out = {m[63], `FPST_EXP_MAX, 1'b1, m[51:0], 11'h0};
        end else if (m[62:52] == 11'h000) begin
          reg_out = (m[51:0] == 52'h0) ? {m[63], 81'h0} :
                    {m[63], `FPST_DBL_DEN, 1'b0, m[51:0], 11'h0};
        end else begin
          reg_out = {m[63], {6'h0, m[62:52]} + `FPST_DBL_ADJ, 1'b1,
                     m[51:0], 11'h0};
        end
      end
      FMT_EXT: begin
        if (m[78:64] == 15'h7fff) begin
          reg_out = {m[79], `FPST_EXP_MAX, m[63:0]};
        end else if (m[78:64] == 15'h0000) begin
          reg_out = {m[79], 17'h0, m[63:0]};
        end else begin
          reg_out = {m[79], {2'h0, m[78:64]} + `FPST_EXT_ADJ, m[63:0]};
        end
      end
      FMT_INT, FMT_SIG: reg_out = {1'b0, `FPST_EXP_INT, m[63:0]};
      FMT_EXP: reg_out = {m[17], m[16:0], `FPST_SIG_EXPMOVE};
      default: reg_out = m[81:0];
    endcase
  end

  always_comb begin
    raw = {46'h0, reg_in};
    case (fmt)
      FMT_SINGLE: begin
        if (re == `FPST_EXP_MAX) begin
          raw = {96'h0, rs, 8'hff, rg[62:40]};
        end else if (!rg[63]) begin
          raw = {96'h0, rs, 8'h00, rg[62:40]};
        end else begin
          raw = {96'h0, rs, sgl_e[7:0], rg[62:40]};
        end
      end
      FMT_DOUBLE: begin
        if (re == `FPST_EXP_MAX) begin
          raw = {64'h0, rs, 11'h7ff, rg[62:11]};
        end else if (!rg[63]) begin
          raw = {64'h0, rs, 11'h000, rg[62:11]};
        end else begin
          raw = {64'h0, rs, dbl_e[10:0], rg[62:11]};
        end
      end
      FMT_EXT: begin
        if (re == `FPST_EXP_MAX) begin
          raw = {48'h0, rs, 15'h7fff, rg};
        end else if (re == 17'h0) begin
          raw = {48'h0, rs, 15'h0000, rg};
        end else begin
          raw = {48'h0, rs, ext_e[14:0], rg};
        end
      end
      FMT_INT, FMT_SIG: raw = {64'h0, rg};
      FMT_EXP: raw = {110'h0, rs, re};
      default: raw = {46'h0, reg_in};
    endcase
  end
endmodule
`default_nettype wire

// ---- verilog/fpst_top.sv ----
// Fp status word with APB access, result controls and fp register transfers
`default_nettype none
`include "fpst_map.svh"
module fpst_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic arith_valid,
  input wire logic [1:0] arith_sf,
  input wire fpst_pkg::fpst_pc_type arith_pc,
  input wire logic ev_invalid,
  input wire logic ev_denorm,
  input wire logic ev_nan_operand,
  input wire logic ev_zero_div,
  input wire logic ev_overflow,
  input wire logic ev_tiny,
  input wire logic ev_inexact,
  input wire logic ev_result_sign,
  output logic rnd_valid,
  output logic [1:0] rnd_prec,
  output logic rnd_wide_exp,
  output logic [1:0] rnd_rc,
  output logic rnd_flush_zero,
  output logic rnd_zero_sign,
  output logic fp_fault,
  output logic fp_trap,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire fpst_pkg::fpst_op_type cmd_op,
  input wire fpst_pkg::fpst_fmt_type cmd_fmt,
  input wire logic cmd_big_endian,
  input wire logic cmd_spec,
  input wire logic [2:0] cmd_dst,
  input wire logic [2:0] cmd_dst2,
  input wire logic [2:0] cmd_src,
  input wire logic [63:0] cmd_base,
  input wire logic cmd_post_inc,
  input wire logic [63:0] cmd_inc,
  input wire logic [63:0] cmd_gr_data,
  input wire logic cmd_gr_nat,
  output logic mem_req,
  output logic mem_we,
  output logic mem_spec,
  output logic [63:0] mem_addr,
  output logic [4:0] mem_bytes,
  output logic [127:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [127:0] mem_rdata,
  input wire logic mem_spec_fail,
  output logic gr_wvalid,
  output logic [63:0] gr_wdata,
  output logic gr_wnat,
  output logic base_wvalid,
  output logic [63:0] base_wdata,
  output logic nat_fault,
  output logic cmd_done
);
  import fpst_pkg::*;

  // Status word storage: exception enable mask and four fields
  logic [5:0] exception_enable_mask;
  logic [12:0] sf [0:3];
  logic [12:0] next_sf [0:3];

  // APB decode
  wire traps_hit = (paddr == `FPST_ADDR_TRAPS);
  wire [11:0] sf_off = paddr - `FPST_ADDR_SF_BASE;
  wire sf_hit = (paddr >= `FPST_ADDR_SF_BASE) &&
                (paddr <= `FPST_ADDR_SF_LAST) && (paddr[1:0] == 2'h0);
  wire [1:0] sf_idx = sf_off[3:2];
  wire addr_hit = traps_hit | sf_hit;
  wire apb_access = psel & penable & ~pready;
  wire apb_commit = psel & penable & pready & pwrite & addr_hit;
  wire [31:0] rd_value = traps_hit ? {26'h0, exception_enable_mask} :
                         sf_hit ? {19'h0, sf[sf_idx]} : 32'h0;

  // Arithmetic status evaluation against the selected field
  wire [12:0] cur = sf[arith_sf];
  wire cur_td = (arith_sf == 2'h0) ? 1'b0 : cur[`FPST_SF_TD];
  wire [5:0] ex_en = ~(exception_enable_mask | {6{cur_td}});
  wire denorm_used = ev_denorm & ~ev_nan_operand;
  wire [2:0] fault_hits = {ev_zero_div, denorm_used, ev_invalid} & ex_en[2:0];
  wire any_fault = |fault_hits;
  wire uf_en = ex_en[`FPST_EX_U];
  wire flush = ev_tiny & ~uf_en & cur[`FPST_SF_FTZ];
  wire u_set = ev_tiny & (uf_en | flush | ev_inexact);
  wire i_set = ev_inexact | flush;
  wire [5:0] set_flags = {i_set, u_set, ev_overflow, ev_zero_div,
                          denorm_used, ev_invalid};
  wire trap_hit = (ev_overflow & ex_en[`FPST_EX_O]) | (ev_tiny & uf_en) |
                  (i_set & ex_en[`FPST_EX_I]);
  wire [1:0] eff_prec = (arith_pc == PC_SINGLE) ? `FPST_PC_SINGLE :
                        (arith_pc == PC_DOUBLE) ? `FPST_PC_DOUBLE :
                        cur[`FPST_SF_PC_LO +: 2];

  // A precise fault leaves the flags alone; hardware set beats a write
  for (genvar gk = 0; gk < 4; gk++) begin : g_sf
    wire sw_wr = apb_commit & sf_hit & (sf_idx == 2'(gk));
    wire [12:0] base_v = sw_wr ? pwdata[12:0] : sf[gk];
    wire own = arith_valid & ~any_fault & (arith_sf == 2'(gk));
    wire [5:0] hw = own ? set_flags : 6'h0;
    wire td_v = (gk == 0) ? 1'b0 : base_v[`FPST_SF_TD];
    assign next_sf[gk] = {base_v[12:7] | hw, td_v, base_v[5:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exception_enable_mask <= `FPST_TRAPS_RST;
      for (int i = 0; i < 4; i++) begin
        sf[i] <= `FPST_SF_RST;
      end
    end else begin
      if (apb_commit && traps_hit) begin
        exception_enable_mask <= pwdata[5:0];
      end
      for (int i = 0; i < 4; i++) begin
        sf[i] <= next_sf[i];
      end
    end
  end

  // One wait state: pready rises the cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & ~addr_hit;
      prdata <= (apb_access && !pwrite) ? rd_value : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_valid <= 1'b0;
      rnd_prec <= 2'h0;
      rnd_wide_exp <= 1'b0;
      rnd_rc <= 2'h0;
      rnd_flush_zero <= 1'b0;
      rnd_zero_sign <= 1'b0;
      fp_fault <= 1'b0;
      fp_trap <= 1'b0;
    end else begin
      rnd_valid <= arith_valid;
      rnd_prec <= eff_prec;
      rnd_wide_exp <= cur[`FPST_SF_WRE];
      rnd_rc <= cur[`FPST_SF_RC_LO +: 2];
      rnd_flush_zero <= arith_valid & flush & ~any_fault;
      rnd_zero_sign <= ev_result_sign;
      fp_fault <= arith_valid & any_fault;
      fp_trap <= arith_valid & ~any_fault & trap_hit;
    end
  end

  // Transfer engine: one command at a time
  fpst_state_type state;
  fpst_op_type op_q;
  fpst_fmt_type fmt_q;
  logic big_q, spec_q, tok_q, postinc_q, fault_q;
  logic [2:0] dst_q, dst2_q, src_q;
  logic [63:0] addr_q, inc_q;
  logic [127:0] buf_q;
  fpst_freg_type rf_rdata;
  fpst_freg_type conv_reg;
  logic [127:0] conv_mem;

  wire is_mem_op = (op_q == OP_LOAD) | (op_q == OP_LOAD_PAIR) |
                   (op_q == OP_STORE);
  wire [4:0] cmd_nbytes = fpst_bytes(cmd_fmt);
  wire cmd_pair = (cmd_op == OP_LOAD_PAIR);
  wire [4:0] req_bytes = cmd_pair ? 5'(cmd_nbytes << 1) : cmd_nbytes;
  // Pair post-increment steps by the whole pair
  wire [63:0] inc_val = cmd_pair ? {59'h0, req_bytes} : cmd_inc;
  wire [127:0] conv_in = (state != ST_WR2) ? buf_q :
                         (fmt_q == FMT_SINGLE) ? (buf_q >> 32) :
                         (buf_q >> 64);
  wire src_tok = (rf_rdata == `FPST_DEFERRED_EXCEPTION_VALUE);
  wire rf_we = (state == ST_WR1) | (state == ST_WR2);
  // Relies on software naming a proper register pair
  wire [2:0] rf_waddr = (state == ST_WR2) ? dst2_q : dst_q;
  wire [81:0] rf_wdata = tok_q ? `FPST_DEFERRED_EXCEPTION_VALUE : conv_reg;

  fpst_regfile u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(src_q),
    .rdata(rf_rdata)
  );

  // Stores trust the register to hold the matching type
  fpst_conv u_conv (
    .fmt(fmt_q),
    .big_endian(big_q & is_mem_op),
    .mem_in(conv_in),
    .reg_in(rf_rdata),
    .reg_out(conv_reg),
    .mem_out(conv_mem)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op_q <= OP_LOAD;
      fmt_q <= FMT_SINGLE;
      {big_q, spec_q, tok_q, postinc_q, fault_q} <= 5'h00;
      {dst_q, dst2_q, src_q} <= 9'h000;
      addr_q <= 64'h0;
      inc_q <= 64'h0;
      buf_q <= 128'h0;
      cmd_ready <= 1'b0;
      {mem_req, mem_we, mem_spec} <= 3'h0;
      mem_addr <= 64'h0;
      mem_bytes <= 5'h00;
      mem_wdata <= 128'h0;
      {gr_wvalid, gr_wnat, base_wvalid, nat_fault, cmd_done} <= 5'h00;
      gr_wdata <= 64'h0;
      base_wdata <= 64'h0;
    end else begin
      {gr_wvalid, base_wvalid, nat_fault, cmd_done} <= 4'h0;
      case (state)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_q <= cmd_op;
            fmt_q <= cmd_fmt;
            big_q <= cmd_big_endian;
            spec_q <= cmd_spec;
            {dst_q, dst2_q, src_q} <= {cmd_dst, cmd_dst2, cmd_src};
            addr_q <= cmd_base;
            postinc_q <= cmd_post_inc;
            inc_q <= inc_val;
            fault_q <= 1'b0;
            buf_q <= {64'h0, cmd_gr_data};
            tok_q <= cmd_gr_nat;
            mem_addr <= cmd_base;
            mem_bytes <= req_bytes;
            mem_spec <= cmd_spec;
            if (cmd_op == OP_LOAD || cmd_pair) begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              state <= ST_MEM;
            end else if (cmd_op == OP_SETF) begin
              state <= ST_WR1;
            end else begin
              state <= ST_RDREG;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (op_q == OP_STORE) begin
              state <= ST_FINISH;
            end else begin
              buf_q <= mem_rdata;
              tok_q <= spec_q & mem_spec_fail;
              state <= ST_WR1;
            end
          end
        end
        ST_WR1: begin
          state <= (op_q == OP_LOAD_PAIR) ? ST_WR2 : ST_FINISH;
        end
        ST_WR2: begin
          state <= ST_FINISH;
        end
        ST_RDREG: begin
          state <= ST_SRC;
        end
        ST_SRC: begin
          if (op_q == OP_GETF) begin
            gr_wvalid <= 1'b1;
            gr_wnat <= src_tok;
            gr_wdata <= src_tok ? 64'h0 : conv_mem[63:0];
            state <= ST_FINISH;
          end else if (src_tok && fmt_q != FMT_SPILL) begin
            nat_fault <= 1'b1;
            fault_q <= 1'b1;
            state <= ST_FINISH;
          end else begin
            mem_wdata <= conv_mem;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            state <= ST_MEM;
          end
        end
        ST_FINISH: begin
          cmd_done <= 1'b1;
          base_wvalid <= postinc_q & is_mem_op & ~fault_q;
          base_wdata <= addr_q + inc_q;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- test/fpst_mem_model.sv ----
// Behavioural memory standing on the far side of the fp transfer port
`default_nettype none
module fpst_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_spec,
  input wire logic [63:0] mem_addr,
  input wire logic [127:0] mem_wdata,
  input wire logic fail,
  input wire logic [2:0] lat,
  output logic mem_ack,
  output logic mem_spec_fail,
  output logic [127:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] mem [0:15];
  logic [2:0] cnt;
  wire logic hit;
  // Answer after lat idle cycles; the ack cycle itself starts no new wait
  assign hit = mem_req && !mem_ack && cnt == lat;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      mem_ack <= 1'b0;
      mem_spec_fail <= 1'b0;
      mem_rdata <= 128'h0;
    end else begin
      mem_ack <= hit;
      cnt <= (mem_req && !hit && !mem_ack) ? cnt + 3'h1 : 3'h0;
      // Only a speculative request can fail softly
      mem_spec_fail <= hit && fail && mem_spec;
      // Released data toggles each cycle, so a stale value comes back on every other cycle
      mem_rdata <= hit ? mem[mem_addr[7:4]] : ~mem_rdata;
      if (hit && mem_we) begin
        mem[mem_addr[7:4]] <= mem_wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/fpst_top_sva.sv ----
// Port assertions for the fp status and transfer block
`default_nettype none
module fpst_top_sva
  import fpst_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic arith_valid,
  input wire logic ev_tiny,
  input wire logic ev_result_sign,
  input wire logic rnd_valid,
  input wire logic rnd_flush_zero,
  input wire logic rnd_zero_sign,
  input wire logic fp_fault,
  input wire logic fp_trap,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire fpst_pkg::fpst_op_type cmd_op,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [63:0] mem_addr,
  input wire logic [4:0] mem_bytes,
  input wire logic nat_fault,
  input wire logic gr_wvalid,
  input wire logic cmd_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_setf;
    s_take ##0 cmd_op == OP_SETF;
  endsequence
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access missed its single wait state");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carried data");
  a_rnd_follow: assert property (rnd_valid == $past(arith_valid))
    else $error("rounding controls not one cycle after operation");
  a_flush_cause: assert property (rnd_flush_zero |->
    $past(arith_valid && ev_tiny) && rnd_zero_sign == $past(ev_result_sign))
    else $error("flush without tiny result or with wrong sign");
  a_irq_cause: assert property (fp_fault || fp_trap |-> $past(arith_valid))
    else $error("exception raised without an operation");
  a_nat_no_mem: assert property (nat_fault |-> !mem_req)
    else $error("token store reached memory");
  a_nat_done: assert property (nat_fault |=> cmd_done)
    else $error("token fault not followed by completion");
  a_getf_done: assert property (gr_wvalid |=> cmd_done)
    else $error("general register write not followed by completion");
  a_setf_done: assert property (s_setf |-> ##[1:4] cmd_done)
    else $error("register move did not complete");
  a_take_busy: assert property (s_take |=> !cmd_ready [*2])
    else $error("command port ready while busy");
  a_done_ready: assert property (cmd_done |=> cmd_ready)
    else $error("command port not ready after completion");
  a_mem_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_bytes))
    else $error("memory request changed before answer");
  a_bytes_legal: assert property (mem_req |->
    mem_bytes inside {5'h04, 5'h08, 5'h0a, 5'h10})
    else $error("memory request size not a supported container");
endmodule
bind fpst_top fpst_top_sva u_sva (.*);
`default_nettype wire

// ---- test/tb_fpst_top.sv ----
// Self-checking bench for the fp status and transfer block
`default_nettype none
module tb_fpst_top
  import fpst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, gn, nf, fail = 1'b0;
  logic arith_valid = 1'b0;
  logic [1:0] arith_sf = 2'h0, rnd_prec, rnd_rc;
  fpst_pc_type arith_pc = PC_NONE;
  logic [7:0] ev = 8'h00;
  logic rnd_valid, rnd_wide_exp, rnd_flush_zero, rnd_zero_sign;
  logic fp_fault, fp_trap, cmd_ready, mem_req, mem_we, mem_spec;
  logic cmd_valid = 1'b0, cmd_big_endian = 1'b0, cmd_spec = 1'b0;
  logic cmd_post_inc = 1'b0, cmd_gr_nat = 1'b0;
  fpst_op_type cmd_op = OP_LOAD;
  fpst_fmt_type cmd_fmt = FMT_SINGLE;
  logic [2:0] cmd_dst = 3'h0, cmd_dst2 = 3'h0, lat = 3'h0;
  logic [63:0] cmd_base = 64'h0, cmd_inc = 64'h0, cmd_gr_data = 64'h0;
  logic mem_ack, mem_spec_fail, gr_wvalid, gr_wnat, base_wvalid;
  logic nat_fault, cmd_done;
  logic [63:0] mem_addr, gr_wdata, base_wdata, gq, bq;
  logic [63:0] seed = 64'h15a45;
  logic [4:0] mem_bytes;
  logic [127:0] mem_wdata, mem_rdata;
  int errors = 0, checked = 0, cyc = 0;
  fpst_top DUT (.*, .ev_invalid(ev[0]), .ev_denorm(ev[1]),
    .ev_nan_operand(ev[2]), .ev_zero_div(ev[3]), .ev_overflow(ev[4]),
    .ev_tiny(ev[5]), .ev_inexact(ev[6]), .ev_result_sign(ev[7]),
    .cmd_src(cmd_dst));
  fpst_mem_model mdl (.*);
  always #20 pclk = ~pclk;
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction
  function automatic logic [63:0] sw(input logic [63:0] d);
    logic [63:0] r;
    for (int i = 0; i < 8; i++) r[8*i +: 8] = d[56-8*i +: 8];
    return r;
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic arith(input logic [1:0] sf, input fpst_pc_type pc,
                       input logic [7:0] e);
    arith_valid <= 1'b1;
    arith_sf <= sf;
    arith_pc <= pc;
    ev <= e;
    @(posedge pclk);
    arith_valid <= 1'b0;
    ev <= 8'h00;
    @(posedge pclk);
  endtask
  task automatic cmd(input fpst_op_type op, input fpst_fmt_type f,
                     input logic [2:0] d, input logic [63:0] g, a);
    logic [63:0] r;
    r = rnd();
    while (cmd_ready !== 1'b1) begin
      @(posedge pclk);
    end
    lat <= r[2:0];
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_fmt <= f;
    cmd_dst <= d;
    cmd_gr_data <= g;
    cmd_base <= a;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    nf = 1'b0;
    do begin
      @(posedge pclk);
      if (gr_wvalid === 1'b1) begin
        gq = gr_wdata;
        gn = gr_wnat;
      end
      if (base_wvalid === 1'b1) bq = base_wdata;
      if (nat_fault === 1'b1) nf = 1'b1;
    end while (cmd_done !== 1'b1);
    @(posedge pclk);
  endtask
  initial begin
    logic [63:0] x, v;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h3f);
    for (int i = 1; i < 5; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h000c);
      x = rnd();
      apb(1'b1, 12'(4 * i), {25'h0, 1'b1, x[5:0]});
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, {25'h0, i != 1, x[5:0]});
    end
    apb(1'b0, 12'h014, 32'h0);
    chk({rd, er}, {32'h0, 1'b1});
    apb(1'b1, 12'h004, 32'h000c);
    apb(1'b1, 12'h008, 32'h000d);
    arith(2'h1, PC_NONE, 8'ha0);
    chk({rnd_flush_zero, rnd_zero_sign, fp_trap}, 3'b110);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h180d);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h000c);
    apb(1'b1, 12'h000, 32'h2f);
    arith(2'h1, PC_NONE, 8'h20);
    chk({rnd_flush_zero, fp_trap}, 2'b01);
    apb(1'b1, 12'h00c, 32'h004c);
    arith(2'h2, PC_NONE, 8'h60);
    chk({fp_trap, fp_fault}, 2'b00);
    apb(1'b1, 12'h000, 32'h3f);
    apb(1'b1, 12'h010, 32'h002e);
    arith(2'h3, PC_NONE, 8'h06);
    chk({rnd_wide_exp, rnd_rc, rnd_prec}, 5'b11011);
    arith(2'h3, PC_SINGLE, 8'h00);
    chk(rnd_prec, 2'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h002e);
    arith(2'h3, PC_NONE, 8'h02);
    arith(2'h3, PC_NONE, 8'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h012e);
    apb(1'b1, 12'h010, 32'h1fac);
    chk(fp_fault, 1'b0);
    apb(1'b1, 12'h000, 32'h3e);
    arith(2'h3, PC_NONE, 8'h01);
    chk(fp_fault, 1'b1);
    x = rnd();
    cmd(OP_SETF, FMT_SIG, 3'h2, x, 64'h0);
    cmd(OP_STORE, FMT_SPILL, 3'h2, 64'h0, 64'h10);
    chk(mdl.mem[1][81:0], {1'b0, 17'h1003e, x});
    cmd(OP_SETF, FMT_EXP, 3'h2, x, 64'h0);
    cmd(OP_STORE, FMT_SPILL, 3'h2, 64'h0, 64'h20);
    chk(mdl.mem[2][81:0], {x[17:0], 64'h8000000000000000});
    cmd_gr_nat <= 1'b1;
    cmd(OP_SETF, FMT_INT, 3'h4, 64'h0, 64'h0);
    cmd_gr_nat <= 1'b0;
    cmd(OP_GETF, FMT_INT, 3'h4, 64'h0, 64'h0);
    chk(gn, 1'b1);
    cmd(OP_STORE, FMT_DOUBLE, 3'h4, 64'h0, 64'h30);
    chk(nf, 1'b1);
    cmd(OP_STORE, FMT_SPILL, 3'h4, 64'h0, 64'h30);
    chk(mdl.mem[3][81:0], {1'b0, 17'h1fffe, 64'h0});
    fail <= 1'b1;
    cmd_spec <= 1'b1;
    cmd(OP_LOAD, FMT_DOUBLE, 3'h3, 64'h0, 64'h40);
    fail <= 1'b0;
    cmd_spec <= 1'b0;
    cmd(OP_STORE, FMT_SPILL, 3'h3, 64'h0, 64'h50);
    chk(mdl.mem[5][81:0], {1'b0, 17'h1fffe, 64'h0});
    cmd_post_inc <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      v = rnd() & 64'h3fffffffffffffff | 64'h2000000000000000;
      mdl.mem[6] = {64'h0, b == 1 ? sw(v) : v};
      x = rnd();
      cmd_big_endian <= b == 1;
      cmd_inc <= x;
      cmd(OP_LOAD, FMT_DOUBLE, 3'h5, 64'h0, 64'h60);
      chk(bq, 64'h60 + x);
      cmd(OP_GETF, FMT_DOUBLE, 3'h5, 64'h0, 64'h0);
      chk(gq, v);
    end
    v = rnd() & 64'h3fffffff3fffffff | 64'h2000000020000000;
    mdl.mem[7] = {64'h0, v};
    cmd_big_endian <= 1'b0;
    cmd_dst2 <= 3'h6;
    cmd(OP_LOAD_PAIR, FMT_SINGLE, 3'h5, 64'h0, 64'h70);
    chk(bq, 64'h78);
    cmd(OP_GETF, FMT_SINGLE, 3'h6, 64'h0, 64'h0);
    chk(gq[31:0], v[63:32]);
    cmd(OP_STORE, FMT_SINGLE, 3'h6, 64'h0, 64'h80);
    chk(mdl.mem[8][31:0], v[63:32]);
    mdl.mem[9] = {48'h0, x[15:0], v};
    cmd(OP_LOAD, FMT_EXT, 3'h1, 64'h0, 64'h90);
    cmd(OP_STORE, FMT_EXT, 3'h1, 64'h0, 64'ha0);
    chk(mdl.mem[10][79:0], {x[15:0], v});
    cmd(OP_LOAD, FMT_SPILL, 3'h7, 64'h0, 64'h30);
    cmd(OP_STORE, FMT_DOUBLE, 3'h7, 64'h0, 64'hb0);
    chk(nf, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
